/* File: rtl/scanner_status_telegram.sv */
// Status telegram framer: system status, scan count, reflector and guard A parts.
// Assumes status inputs come from logic on mclk_i; only the revolution mark is a pin.
`timescale 1ns/1ps
`include "scanner_status_consts.svh"
module scanner_status_telegram (
	// Clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          resetn_i,
	// Measuring head revolution mark (pin)
	input  wire logic                          rev_mark_i,
	// System status sources
	input  wire scanner_status_pkg::byte_t     operating_state_code_i,
	input  wire logic                          error_i,
	input  wire logic                          warning_i,
	input  wire logic                          dirt_warn_i,
	input  wire logic                          dirt_off_i,
	input  wire logic                          pair_fault_i,
	input  wire logic                          parked_i,
	input  wire scanner_status_pkg::half_t     tilt_h_i,
	input  wire scanner_status_pkg::half_t     tilt_v_i,
	input  wire scanner_status_pkg::half_t     internal_temperature_i,
	// Guard A sources
	input  wire logic                          guard_a_active_i,
	input  wire logic                          guard_a_warn_zone_clear_i,
	input  wire logic                          guard_a_stop_zone_clear_i,
	input  wire logic                          guard_a_warn_segment1_clear_i,
	input  wire logic                          guard_a_warn_segment2_clear_i,
	input  wire logic                          guard_a_stop_segment1_clear_i,
	input  wire logic                          guard_a_stop_segment2_clear_i,
	input  wire scanner_status_pkg::pair_num_t guard_a_pair1_i,
	input  wire scanner_status_pkg::pair_num_t guard_a_pair2_i,
	input  wire scanner_status_pkg::pair_num_t guard_a_pair3_i,
	input  wire logic                          guard_a_preset_match1_i,
	input  wire logic                          guard_a_preset_match2_i,
	// Telegram byte port
	input  wire logic [4:0]                    tele_addr_i,
	output scanner_status_pkg::byte_t          tele_byte_o,
	output logic                               tele_safe_o,
	output logic                               tele_update_o,
	// Register port
	input  wire logic [7:0]                    reg_addr_i,
	input  wire scanner_status_pkg::word_t     reg_wdata_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	output scanner_status_pkg::word_t          reg_rdata_o,
	// Interrupt
	output logic                               irq_o
);
	// ----------------------------------------
	// Revolution event and scan count
	// ----------------------------------------
	logic                      rev_level;
	logic                      rev_prev;
	logic                      rev_evt;
	logic                      cap;
	logic                      wrap;
	scanner_status_pkg::word_t scan_count;

	pin_sync3 #(
		.W (1)
	) u_rev_sync (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.async_i  (rev_mark_i),
		.level_o  (rev_level)
	);

	// Rising edge of the filtered mark ends a revolution
	assign rev_evt = rev_level && !rev_prev;

	scan_counter u_scan (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.inc_i    (rev_evt),
		.count_o  (scan_count),
		.wrap_o   (wrap)
	);

	// Capture one cycle late so the stepped count is framed
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			rev_prev <= 1'b0;
			cap      <= 1'b0;
		end
		else
		begin
			rev_prev <= rev_level;
			cap      <= rev_evt;
		end
	end

	// ----------------------------------------
	// Next telegram assembly
	// ----------------------------------------
	scanner_status_pkg::byte_t next_tele [0:`TB_LAST];
	logic                      dirt_any;
	logic                      warn_any;
	logic                      pair_bad;

	assign dirt_any = dirt_warn_i || dirt_off_i;
	assign warn_any = warning_i || dirt_warn_i;

	assign next_tele[`TB_MODE] = operating_state_code_i;
	// Upper three bits reserved
	assign next_tele[`TB_FLAGS] = {3'h0, parked_i, pair_fault_i,
		dirt_any, warn_any, error_i};
	// Multi-byte fields go most significant byte first
	assign next_tele[`TB_TILT_H]     = tilt_h_i[15:8];
	assign next_tele[`TB_TILT_H + 1] = tilt_h_i[7:0];
	assign next_tele[`TB_TILT_V]     = tilt_v_i[15:8];
	assign next_tele[`TB_TILT_V + 1] = tilt_v_i[7:0];
	assign next_tele[`TB_TEMP]       = internal_temperature_i[15:8];
	assign next_tele[`TB_TEMP + 1]   = internal_temperature_i[7:0];
	assign next_tele[`TB_SCAN]       = scan_count[31:24];
	assign next_tele[`TB_SCAN + 1]   = scan_count[23:16];
	assign next_tele[`TB_SCAN + 2]   = scan_count[15:8];
	assign next_tele[`TB_SCAN + 3]   = scan_count[7:0];
	// Reflector search is not built; the part stays empty
	assign next_tele[`TB_REFL]       = 8'h00;
	assign next_tele[`TB_REFL + 1]   = 8'h00;
	assign next_tele[`TB_GA] = {1'b0,
		guard_a_stop_segment2_clear_i, guard_a_stop_segment1_clear_i,
		guard_a_warn_segment2_clear_i, guard_a_warn_segment1_clear_i,
		guard_a_stop_zone_clear_i, guard_a_warn_zone_clear_i,
		guard_a_active_i};
	assign next_tele[`TB_GA_PAIR] = {guard_a_pair2_i, guard_a_pair1_i};
	assign next_tele[`TB_GA_SEL]  = {guard_a_preset_match2_i, guard_a_preset_match1_i,
		2'h0, guard_a_pair3_i};

	// Numbers outside 1..10 are passed on, and flagged to software at a snapshot taken while guard A is active
	function automatic logic pair_out(input scanner_status_pkg::pair_num_t p);
		pair_out = (p < `PAIR_MIN) || (p > `PAIR_MAX);
	endfunction
	assign pair_bad = guard_a_active_i && (pair_out(guard_a_pair1_i) ||
		pair_out(guard_a_pair2_i) || pair_out(guard_a_pair3_i));

	// ----------------------------------------
	// Telegram snapshot
	// ----------------------------------------
	scanner_status_pkg::byte_t tele [0:`TB_LAST];
	logic                      freeze;
	logic                      take;

	// Freeze lets software read a consistent set across revolutions
	assign take = cap && !freeze;

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			for (int i = 0; i <= `TB_LAST; i++)
				tele[i] <= 8'h00;
		else if (take)
			for (int i = 0; i <= `TB_LAST; i++)
				tele[i] <= next_tele[i];
	end

	// ----------------------------------------
	// Telegram byte port
	// ----------------------------------------
	logic                      addr_in;
	logic                      addr_safe;
	scanner_status_pkg::byte_t sel_byte;

	assign addr_in   = tele_addr_i <= 5'(`TB_LAST);
	assign addr_safe = tele_addr_i >= 5'(`TB_SCAN) && tele_addr_i <= 5'(`TB_SCAN + 3);
	assign sel_byte  = addr_in ? tele[tele_addr_i] : 8'h00;

	// Byte and its safety mark appear one cycle after the address
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			tele_byte_o   <= 8'h00;
			tele_safe_o   <= 1'b0;
			tele_update_o <= 1'b0;
		end
		else
		begin
			tele_byte_o   <= sel_byte;
			tele_safe_o   <= addr_safe;
			tele_update_o <= take;
		end
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	logic [`IRQ_W-1:0] irq_stat;
	logic [`IRQ_W-1:0] irq_mask;
	logic [`IRQ_W-1:0] irq_evt;
	logic [`IRQ_W-1:0] irq_clr;
	logic              err_prev;
	logic              stop_prev;
	logic              wr_stat;
	logic              wr_mask;
	logic              wr_ctrl;

	assign irq_evt[`IRQ_SCAN]  = take;
	assign irq_evt[`IRQ_ERROR] = error_i && !err_prev;
	assign irq_evt[`IRQ_STOP]  = guard_a_active_i && stop_prev && !guard_a_stop_zone_clear_i;
	assign irq_evt[`IRQ_WRAP]  = wrap;
	assign irq_evt[`IRQ_PAIR]  = take && pair_bad;

	assign wr_stat = reg_wr_i && reg_addr_i == `RA_IRQ_STAT;
	assign wr_mask = reg_wr_i && reg_addr_i == `RA_IRQ_MASK;
	assign wr_ctrl = reg_wr_i && reg_addr_i == `RA_CTRL;
	assign irq_clr = wr_stat ? reg_wdata_i[`IRQ_W-1:0] : '0;

	// Write one to clear; a same-cycle event keeps its bit set
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			irq_stat  <= `IRQ_RST;
			irq_mask  <= `IRQ_RST;
			freeze    <= `CTRL_RST;
			err_prev  <= 1'b0;
			stop_prev <= 1'b1;
			irq_o     <= 1'b0;
		end
		else
		begin
			irq_stat  <= (irq_stat & ~irq_clr) | irq_evt;
			err_prev  <= error_i;
			stop_prev <= guard_a_stop_zone_clear_i;
			irq_o     <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_mask);
			if (wr_mask)
				irq_mask <= reg_wdata_i[`IRQ_W-1:0];
			if (wr_ctrl)
				freeze <= reg_wdata_i[`CTRL_FREEZE];
		end
	end

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	scanner_status_pkg::word_t tele_word;
	scanner_status_pkg::word_t live_flags;
	scanner_status_pkg::word_t next_rdata;
	logic [2:0]                word_idx;
	logic                      is_tele;

	assign is_tele  = reg_addr_i >= `RA_TELE_W0 && reg_addr_i <= `RA_TELE_WN;
	assign word_idx = 3'((reg_addr_i - `RA_TELE_W0) >> 2);

	// Word n holds telegram bytes 4n..4n+3, lowest byte in bits 7:0
	always_comb
	begin
		tele_word = 32'h0000_0000;
		for (int b = 0; b < 4; b++)
			if (int'(word_idx) * 4 + b <= `TB_LAST)
				tele_word[b*8 +: 8] = tele[int'(word_idx) * 4 + b];
	end

	assign live_flags = {16'h0000, next_tele[`TB_GA], next_tele[`TB_FLAGS]};

	assign next_rdata =
		(reg_addr_i == `RA_CTRL)      ? {31'h0, freeze} :
		(reg_addr_i == `RA_IRQ_STAT)  ? {27'h0, irq_stat} :
		(reg_addr_i == `RA_IRQ_MASK)  ? {27'h0, irq_mask} :
		(reg_addr_i == `RA_SCAN_LIVE) ? scan_count :
		(reg_addr_i == `RA_LIVE_FLG)  ? live_flags :
		(reg_addr_i == `RA_MOD_ID)    ? `ID_MODULE :
		(reg_addr_i == `RA_SUB_IDS)   ? {`SUB_GUARD_A, `SUB_REFL, `SUB_SCAN, `SUB_SYSTEM} :
		is_tele                       ? tele_word : 32'h0000_0000;

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			reg_rdata_o <= 32'h0000_0000;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
		else
			reg_rdata_o <= 32'h0000_0000;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_mode_byte: assert property (take |=> tele[`TB_MODE] == $past(operating_state_code_i))
		else $error("mode byte not captured");
	a_flag_bits: assert property (take |=> tele[`TB_FLAGS][1:0] ==
		{$past(warning_i) | $past(dirt_warn_i), $past(error_i)})
		else $error("error or warning bit wrong");
	a_dirt_bit: assert property (take |=> tele[`TB_FLAGS][2] ==
		($past(dirt_warn_i) | $past(dirt_off_i)))
		else $error("dirt bit wrong");
	a_tilt_fields: assert property (take |=>
		{tele[`TB_TILT_H], tele[`TB_TILT_H + 1], tele[`TB_TILT_V], tele[`TB_TILT_V + 1]} ==
		{$past(tilt_h_i), $past(tilt_v_i)})
		else $error("tilt fields wrong");
	a_temp_field: assert property (take |=> {tele[`TB_TEMP], tele[`TB_TEMP + 1]} ==
		$past(internal_temperature_i))
		else $error("temperature field wrong");
	a_rev_count: assert property ($rose(rev_level) |=> cap ##0
		scan_count == $past(scan_count) + 32'h0000_0001)
		else $error("revolution did not advance count");
	a_scan_field: assert property (take |=> {tele[`TB_SCAN], tele[`TB_SCAN + 1],
		tele[`TB_SCAN + 2], tele[`TB_SCAN + 3]} == $past(scan_count))
		else $error("scan field wrong");
	a_safe_mark: assert property (tele_addr_i == 5'(`TB_SCAN) |=> tele_safe_o)
		else $error("scan byte not marked safe");
	a_refl_zero: assert property (tele[`TB_REFL] == 8'h00 && tele[`TB_REFL + 1] == 8'h00)
		else $error("reflector part not zero");
	a_guard_bits: assert property (take |=> tele[`TB_GA][6:0] ==
		{$past(guard_a_stop_segment2_clear_i), $past(guard_a_stop_segment1_clear_i),
		$past(guard_a_warn_segment2_clear_i), $past(guard_a_warn_segment1_clear_i),
		$past(guard_a_stop_zone_clear_i), $past(guard_a_warn_zone_clear_i),
		$past(guard_a_active_i)})
		else $error("guard A status byte wrong");
	a_pair_nums: assert property (take |=> {tele[`TB_GA_SEL][3:0], tele[`TB_GA_PAIR]} ==
		{$past(guard_a_pair3_i), $past(guard_a_pair2_i), $past(guard_a_pair1_i)})
		else $error("pair numbers wrong");
	a_preset_bits: assert property (take |=> tele[`TB_GA_SEL][7:6] ==
		{$past(guard_a_preset_match2_i), $past(guard_a_preset_match1_i)})
		else $error("preset match bits wrong");
	a_reserved_zero: assert property (tele[`TB_FLAGS][7:5] == 3'h0 && !tele[`TB_GA][7] &&
		tele[`TB_GA_SEL][5:4] == 2'h0)
		else $error("reserved bit set");
	a_sub_ids: assert property (reg_rd_i && reg_addr_i == `RA_SUB_IDS |=>
		reg_rdata_o[15:8] == `SUB_SCAN)
		else $error("scan part identifier wrong");
	// A clear in the same cycle legitimately drops the level
	a_irq_level: assert property (irq_stat[`IRQ_SCAN] && irq_mask[`IRQ_SCAN] &&
		!irq_clr[`IRQ_SCAN] |=> irq_o)
		else $error("masked-in status did not raise interrupt");
endmodule

/* File: rtl/scanner_status_consts.svh */
// Offsets, field positions, reset values and identifiers of the status telegram.
// Assumes inclusion by bare name from the rtl/ files.
`ifndef SCANNER_STATUS_CONSTS_SVH
`define SCANNER_STATUS_CONSTS_SVH

// ----------------------------------------
// Telegram byte positions
// ----------------------------------------
`define TB_MODE      0
`define TB_FLAGS     1
`define TB_TILT_H    2
`define TB_TILT_V    4
`define TB_TEMP      6
`define TB_SCAN      8
`define TB_REFL      12
`define TB_GA        14
`define TB_GA_PAIR   15
`define TB_GA_SEL    16
`define TB_LAST      16
`define TB_WORDS     5

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RA_CTRL      8'h00
`define RA_IRQ_STAT  8'h04
`define RA_IRQ_MASK  8'h08
`define RA_SCAN_LIVE 8'h0c
`define RA_LIVE_FLG  8'h10
`define RA_TELE_W0   8'h20
`define RA_TELE_WN   8'h30
`define RA_MOD_ID    8'h40
`define RA_SUB_IDS   8'h44

// ----------------------------------------
// Control and interrupt bits
// ----------------------------------------
`define CTRL_FREEZE  0
`define IRQ_SCAN     0
`define IRQ_ERROR    1
`define IRQ_STOP     2
`define IRQ_WRAP     3
`define IRQ_PAIR     4
`define IRQ_W        5
`define IRQ_RST      5'h00
`define CTRL_RST     1'h0

// ----------------------------------------
// Part identifiers
// ----------------------------------------
`define ID_MODULE    32'h0000_0002
`define SUB_SYSTEM   8'h02
`define SUB_SCAN     8'h03
`define SUB_REFL     8'h04
`define SUB_GUARD_A  8'h05

// ----------------------------------------
// Field pair number range
// ----------------------------------------
`define PAIR_MIN     4'h1
`define PAIR_MAX     4'ha

`endif

/* File: rtl/scanner_status_pkg.sv */
// Types shared by the status telegram framer.
// Assumes nothing beyond a SystemVerilog compiler.
package scanner_status_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] half_t;
	typedef logic [31:0] word_t;
	typedef logic [3:0]  pair_num_t;
endpackage

/* File: rtl/pin_sync3.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	// Pin side
	input  wire logic [W-1:0] async_i,
	// Clock domain side
	output logic      [W-1:0] level_o
);
	logic [W-1:0] meta;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Metastability chain; first stage feeds only the second
	always_ff @(posedge mclk_i)
	begin
		meta   <= async_i;
		stage2 <= meta;
		stage3 <= stage2;
	end

	// Accept a new level only after two stages agree, per bit
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			level_o <= '0;
		else
			for (int i = 0; i < W; i++)
				if (stage2[i] == stage3[i])
					level_o[i] <= stage3[i];
	end
endmodule

/* File: rtl/scan_counter.sv */
// Free-running 32-bit count of measuring head revolutions.
// Assumes a one-cycle increment pulse; cleared only by the power-on reset.
`timescale 1ns/1ps
module scan_counter (
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       resetn_i,
	// Revolution event
	input  wire logic                       inc_i,
	// Count and overflow
	output scanner_status_pkg::word_t       count_o,
	output logic                            wrap_o
);
	// Count wraps naturally past all ones
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			count_o <= '0;
			wrap_o  <= 1'b0;
		end
		else
		begin
			wrap_o <= inc_i && (count_o == '1);
			if (inc_i)
				count_o <= count_o + 32'h0000_0001;
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_count_step: assert property (inc_i |=> count_o == $past(count_o) + 32'h0000_0001)
		else $error("scan count did not step by one");
	a_count_hold: assert property (!inc_i |=> $stable(count_o))
		else $error("scan count moved without a revolution");
	a_count_wrap: assert property (inc_i && count_o == '1 |=> count_o == '0 && wrap_o)
		else $error("scan count did not restart at zero");
endmodule

/* File: verif/telegram_reader.sv */
// Fieldbus-side reader model: sweeps telegram bytes 0..17 and keeps each answer.
// Assumes the framer answers one cycle after it samples the byte address.
`timescale 1ns/1ps
module telegram_reader (
	// Clock
	input  wire logic       mclk_i,
	// Sweep control
	input  wire logic       start_i,
	output logic            busy_o,
	// Telegram byte port
	output logic [4:0]      tele_addr_o,
	input  wire logic [7:0] tele_byte_i,
	input  wire logic       tele_safe_i,
	// Collected telegram
	output logic [7:0]      frame_o [18],
	output logic [17:0]     safe_o
);
	logic [4:0] ph = 5'h14;

	// Answer to address k stands while ph is k+1; store it at that edge
	always_ff @(posedge mclk_i)
	begin
		if (start_i)
			ph <= 5'h00;
		else if (ph != 5'h14)
			ph <= ph + 5'h01;
		if (ph >= 5'h01 && ph <= 5'h12)
		begin
			frame_o[ph - 5'h01] <= tele_byte_i;
			safe_o[ph - 5'h01]  <= tele_safe_i;
		end
	end

	// Idle address 20 lies past the telegram, so idle reads cost nothing
	assign tele_addr_o = ph;
	assign busy_o      = (ph != 5'h14);
endmodule

/* File: verif/scanner_status_telegram_bench.sv */
// Self-checking bench for the status telegram framer.
// Assumes the reader model beside it and a 50 MHz single clock.
`timescale 1ns/1ps
module scanner_status_telegram_bench;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic mclk_i = 1'b0, resetn_i = 1'b0, rev_mark_i = 1'b0, start = 1'b0, busy;
	scanner_status_pkg::byte_t operating_state_code_i = 8'h00, tele_byte_o;
	logic error_i = 0, warning_i = 0, dirt_warn_i = 0, dirt_off_i = 0, pair_fault_i = 0;
	logic parked_i = 0, guard_a_active_i = 0, guard_a_warn_zone_clear_i = 0;
	logic guard_a_stop_zone_clear_i = 0, guard_a_warn_segment1_clear_i = 0;
	logic guard_a_warn_segment2_clear_i = 0, guard_a_stop_segment1_clear_i = 0;
	logic guard_a_stop_segment2_clear_i = 0, guard_a_preset_match1_i = 0;
	logic guard_a_preset_match2_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic tele_safe_o, tele_update_o, irq_o, seen = 1'b0;
	scanner_status_pkg::half_t tilt_h_i = 16'h0000, tilt_v_i = 16'h0000;
	scanner_status_pkg::half_t internal_temperature_i = 16'h0000;
	scanner_status_pkg::pair_num_t guard_a_pair1_i = 4'h1, guard_a_pair2_i = 4'h1;
	scanner_status_pkg::pair_num_t guard_a_pair3_i = 4'h1;
	logic [4:0] tele_addr_i;
	logic [7:0] reg_addr_i = 8'h00, frame [18];
	logic [17:0] safe;
	scanner_status_pkg::word_t reg_wdata_i = 32'h0, reg_rdata_o, rd, cnt = 32'h0;
	logic [31:0] seed = 32'h44;
	int fail_count = 0, total_checks = 0, cycles = 0;

	always #10 mclk_i = ~mclk_i;

	scanner_status_telegram dut (.mclk_i, .resetn_i, .rev_mark_i, .operating_state_code_i,
		.error_i, .warning_i, .dirt_warn_i, .dirt_off_i, .pair_fault_i, .parked_i,
		.tilt_h_i, .tilt_v_i, .internal_temperature_i, .guard_a_active_i,
		.guard_a_warn_zone_clear_i, .guard_a_stop_zone_clear_i,
		.guard_a_warn_segment1_clear_i, .guard_a_warn_segment2_clear_i,
		.guard_a_stop_segment1_clear_i, .guard_a_stop_segment2_clear_i,
		.guard_a_pair1_i, .guard_a_pair2_i, .guard_a_pair3_i, .guard_a_preset_match1_i,
		.guard_a_preset_match2_i, .tele_addr_i, .tele_byte_o, .tele_safe_o, .tele_update_o,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);

	telegram_reader reader (.mclk_i(mclk_i), .start_i(start), .busy_o(busy),
		.tele_addr_o(tele_addr_i), .tele_byte_i(tele_byte_o), .tele_safe_i(tele_safe_o),
		.frame_o(frame), .safe_o(safe));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Xorshift keeps runs repeatable without a simulator seed
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected telegram byte from the levels driven; wide fields high byte first
	function automatic logic [7:0] exp_byte(int i);
		case (i)
			0: return operating_state_code_i;
			1: return {3'h0, parked_i, pair_fault_i, dirt_warn_i | dirt_off_i,
				warning_i | dirt_warn_i, error_i};
			2: return tilt_h_i[15:8];
			3: return tilt_h_i[7:0];
			4: return tilt_v_i[15:8];
			5: return tilt_v_i[7:0];
			6: return internal_temperature_i[15:8];
			7: return internal_temperature_i[7:0];
			8, 9, 10, 11: return 8'(cnt >> (8 * (11 - i)));
			14: return {1'b0, guard_a_stop_segment2_clear_i, guard_a_stop_segment1_clear_i,
				guard_a_warn_segment2_clear_i, guard_a_warn_segment1_clear_i,
				guard_a_stop_zone_clear_i, guard_a_warn_zone_clear_i, guard_a_active_i};
			15: return {guard_a_pair2_i, guard_a_pair1_i};
			16: return {guard_a_preset_match2_i, guard_a_preset_match1_i, 2'h0, guard_a_pair3_i};
			default: return 8'h00;
		endcase
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One-cycle strobes, launched just after an edge
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i    <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i   <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// Corner sets first, then random levels; pair numbers stay in 1..10
	task automatic drive_status(input int n);
		logic [31:0] r;
		r = rnd();
		@(posedge mclk_i);
		operating_state_code_i <= (n == 0) ? 8'hff : (n == 1) ? 8'h00 : r[7:0];
		{parked_i, pair_fault_i, dirt_warn_i, warning_i} <= (n < 2) ? {4{n == 0}} : r[11:8];
		dirt_off_i <= (n == 0) | r[12];
		error_i    <= (n == 0) | r[12] | r[13];
		{guard_a_stop_segment2_clear_i, guard_a_stop_segment1_clear_i,
			guard_a_warn_segment2_clear_i, guard_a_warn_segment1_clear_i,
			guard_a_stop_zone_clear_i, guard_a_warn_zone_clear_i,
			guard_a_active_i} <= (n < 2) ? {7{n == 0}} : r[20:14];
		{guard_a_preset_match2_i, guard_a_preset_match1_i} <= (n < 2) ? {2{n == 0}} : r[22:21];
		guard_a_pair1_i <= (n == 0) ? 4'ha : (n == 1) ? 4'h1 : 4'(r[23:0] % 10 + 1);
		guard_a_pair2_i <= (n < 2) ? 4'h1 : 4'(r[31:8] % 10 + 1);
		guard_a_pair3_i <= (n < 2) ? 4'ha : 4'(r[27:4] % 10 + 1);
		r = rnd();
		tilt_h_i <= (n == 0) ? 16'h8000 : r[15:0];
		tilt_v_i <= (n == 0) ? 16'h7fff : r[31:16];
		internal_temperature_i <= (n == 0) ? 16'hffff : r[23:8];
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Run is under 2000 cycles; this ceiling leaves ample margin
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			$display("[FAIL] t=%0t run timed out", $time);
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		reg_read(8'h0c, rd);
		check(rd, 32'h0, "count after power-on");
		reg_read(8'h7c, rd);
		check(rd, 32'h0, "unmapped read");
		reg_read(8'h44, rd);
		check(rd, 32'h05040302, "part identifiers");
		reg_write(8'h08, 32'h1);
		for (int n = 0; n < 8; n++)
		begin
			if (n == 5)
				reg_write(8'h08, 32'h0);
			drive_status(n);
			repeat (2) @(posedge mclk_i);
			rev_mark_i <= 1'b1;
			for (int k = 0; k < 20 && tele_update_o !== 1'b1; k++)
				@(posedge mclk_i) #1;
			check(tele_update_o, 1'b1, "snapshot pulse");
			cnt = cnt + 32'h1;
			check(irq_o, n < 5, "irq level");
			@(posedge mclk_i);
			rev_mark_i <= 1'b0;
			start      <= 1'b1;
			@(posedge mclk_i);
			start <= 1'b0;
			repeat (30) @(posedge mclk_i);
			for (int i = 0; i < 2; i++)
				check(frame[i], exp_byte(i), "status byte");
			for (int i = 2; i < 8; i++)
				check(frame[i], exp_byte(i), "tilt or temp byte");
			for (int i = 8; i < 12; i++)
				check(frame[i], exp_byte(i), "scan byte");
			check({frame[12], frame[13]}, 16'h0, "reflector part");
			for (int i = 14; i < 17; i++)
				check(frame[i], exp_byte(i), "guard byte");
			check(frame[17], 8'h00, "past telegram end");
			check(safe, 18'h00f00, "safe marking");
			reg_write(8'h04, 32'h1f);
			repeat (2) @(posedge mclk_i);
			#1 check(irq_o, 1'b0, "irq after clear");
			$display("test %0d done", n);
		end
		// Frozen snapshot: count steps, but no capture and no update pulse
		reg_write(8'h00, 32'h1);
		rev_mark_i <= 1'b1;
		for (int k = 0; k < 12; k++)
		begin
			@(posedge mclk_i) #1;
			seen = seen | tele_update_o;
		end
		check(seen, 1'b0, "pulse while frozen");
		@(posedge mclk_i);
		rev_mark_i <= 1'b0;
		start      <= 1'b1;
		@(posedge mclk_i);
		start <= 1'b0;
		repeat (30) @(posedge mclk_i);
		for (int i = 8; i < 12; i++)
			check(frame[i], exp_byte(i), "frozen scan byte");
		// Word reads: lowest telegram byte in bits 7:0
		reg_read(8'h20, rd);
		check(rd, {exp_byte(3), exp_byte(2), exp_byte(1), exp_byte(0)}, "word 0");
		reg_read(8'h28, rd);
		check(rd, {exp_byte(11), exp_byte(10), exp_byte(9), exp_byte(8)}, "word 2");
		reg_read(8'h40, rd);
		check(rd, 32'h2, "module identifier");
		cnt = cnt + 32'h1;
		$display("test freeze done");
		reg_read(8'h0c, rd);
		check(rd, cnt, "live count");
		tally_and_finish();
	end
endmodule
